// ### bench/driver_config_status_regs_bench.sv
// bench: host frames to the register bank, checks outputs and responses
// assumes the host model and the checker bind are compiled first
`default_nettype none
module driver_config_status_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, arst_n, sclk, cs_n, mosi, miso, moe, ovh, fwd, dts, dis;
   logic [3:0]  flt;
   logic [31:0] flags;
   logic [5:0]  rate;
   logic [2:0]  fast, slew;
   logic [8:0]  crate;
   logic [7:0]  st, v;
   logic [7:0]  fmask [4] = '{8'h20, 8'h10, 8'h04, 8'h02};
   logic [15:0] rx;
   int          num_errors, n_checks, cycles;

   driver_config_status_regs dut_u (
      .i_clk_sys(clk), .i_arst_n(arst_n), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
      .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(moe), .i_supply_uv(flt[3]),
      .i_supply_ov(flt[2]), .i_thermal_sd(flt[1]), .i_thermal_pw(flt[0]),
      .i_load_fault_flags(flags), .i_pwm_rate_code(rate), .o_ov_thresh_high(ovh),
      .o_fast_pwm_select(fast), .o_freewheel_openload_disable(fwd),
      .o_dead_time_short(dts), .o_slew_rate_code(slew), .o_chan_rate(crate),
      .o_global_fault_status(st), .o_outputs_disable(dis));
   spi_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one frame; r is the response of the frame before
   task acc(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      host_u.xfer({a, d}, 16, rx);
      @(negedge clk);
      r = rx[7:0];
   endtask
   task rd(input logic [7:0] a, output logic [7:0] r);
      acc(a, 8'h00, r);
      acc(8'h01, 8'h00, r);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         stop_test();
      end
   end
   // output enable must be up once the first link fall of a frame has passed
   always @(negedge cs_n) begin
      @(posedge sclk);
      @(posedge sclk);
      chk(moe, 1'b1);
   end

   initial begin
      arst_n = 1'b0;
      flt = 4'h0;
      flags = 32'h0000_0000;
      rate = 6'h00;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      chk(st, 8'h00);
      chk({ovh, fast, fwd, dts, slew}, 16'h0000);
      rd(8'h0D, v); chk(v, 8'h00);
      rd(8'h1D, v); chk(v, 8'h00);
      rd(8'h19, v); chk(v, 8'h00);
      acc(8'h8D, 8'hFF, v);
      rd(8'h0D, v); chk(v, driver_regs_pkg::WMASK_OV_FAST);
      chk({ovh, fast}, 16'h000F);
      chk(crate, 16'h0124);
      acc(8'h9D, 8'hFF, v);
      rd(8'h1D, v); chk(v, driver_regs_pkg::WMASK_OL_DT_SR);
      chk({fwd, dts}, 16'h0003);
      for (int c = 0; c < 8; c++) begin
         acc(8'h9D, 8'(c), v);
         chk(slew, 16'(c));
      end
      acc(8'h8D, 8'h00, v);
      @(posedge clk) rate <= 6'h39;
      repeat (2) @(negedge clk);
      chk(crate, 16'h00D1);
      @(posedge clk) rate <= 6'h04;
      repeat (2) @(negedge clk);
      chk(crate, 16'h0008);
      acc(8'h99, 8'h00, v); acc(8'h01, 8'h00, v); chk(v, 8'h00);
      chk(st, 8'h08);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk) flt <= 4'h8 >> k;
         repeat (6) @(posedge clk);
         flt <= 4'h0;
         repeat (8) @(negedge clk);
         chk(st, 8'h08 | fmask[k]);
         chk(dis, 16'(k != 3));
         rd(8'h19, v); chk(v, 8'h08 | fmask[k]);
         acc(8'h99, 8'h00, v); chk(st, 8'h08);
      end
      @(posedge clk) flags <= 32'h8000_0000;
      repeat (3) @(negedge clk);
      chk(st[6], 1'b1);
      acc(8'h99, 8'h00, v); chk(st[6], 1'b1);
      @(posedge clk) flags <= 32'h0000_0000;
      repeat (3) @(negedge clk);
      chk(st[6], 1'b0);
      host_u.xfer(16'h0100, 15, rx);
      @(negedge clk);
      chk(st, 8'h88);
      acc(8'h01, 8'h00, v); chk(v, 8'h00);
      acc(8'h99, 8'h00, v); acc(8'h01, 8'h00, v); chk(v, 8'h88);
      chk(st, 8'h08);
      chk({moe, miso}, 16'h0000);
      stop_test();
   end
endmodule // driver_config_status_regs_bench
`default_nettype wire

// ### bench/driver_regs_assertions.sv
// checker: status, disable and rate relations of the register bank
// assumes it is bound to the bank's top module
`default_nettype none
module driver_regs_assertions #(
   parameter int unsigned N_CHAN      = 3,
   parameter int unsigned N_LOAD_FLAG = 32
) (
   // clock and reset
   input wire logic                   i_clk_sys,
   input wire logic                   i_arst_n,
   // inputs watched
   input wire logic                   i_spi_cs_n,
   input wire logic                   i_supply_uv,
   input wire logic                   i_supply_ov,
   input wire logic                   i_thermal_sd,
   input wire logic [N_LOAD_FLAG-1:0] i_load_fault_flags,
   input wire logic [2*N_CHAN-1:0]    i_pwm_rate_code,
   // outputs watched
   input wire logic [N_CHAN-1:0]      o_fast_pwm_select,
   input wire logic [3*N_CHAN-1:0]    o_chan_rate,
   input wire logic [7:0]             o_global_fault_status,
   input wire logic                   o_outputs_disable
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   sequence s_uv_held; i_supply_uv [*4]; endsequence
   sequence s_ov_held; i_supply_ov [*4]; endsequence
   sequence s_sd_held; i_thermal_sd [*4]; endsequence
   sequence s_link_idle; i_spi_cs_n [*7]; endsequence
   a_status_bit0_zero:
      assert property (o_global_fault_status[0] == 1'b0)
      else $error("status bit 0 not zero");
   a_uv_latched:
      assert property (s_uv_held |-> o_global_fault_status[5])
      else $error("undervoltage flag not set");
   a_ov_latched:
      assert property (s_ov_held |-> o_global_fault_status[4])
      else $error("overvoltage flag not set");
   a_sd_latched:
      assert property (s_sd_held |-> o_global_fault_status[2])
      else $error("thermal shutdown flag not set");
   a_disable_match:
      assert property (o_outputs_disable == |(o_global_fault_status & 8'h34))
      else $error("outputs disable wrong");
   a_no_self_clear:
      assert property (s_link_idle |=>
         (~o_global_fault_status & $past(o_global_fault_status) & 8'hB6) == 8'h00)
      else $error("flag fell without clear");
   a_load_summary:
      assert property ($past(i_arst_n) |->
         o_global_fault_status[6] == $past(|i_load_fault_flags))
      else $error("load summary wrong");
   a_fast_wins:
      assert property (o_fast_pwm_select[0] && $past(o_fast_pwm_select[0])
         |-> o_chan_rate[2:0] == 3'h4)
      else $error("fast rate not chosen");
   a_rate_code:
      assert property ($past(i_arst_n) && !o_fast_pwm_select[1] && !$past(o_fast_pwm_select[1])
         |-> o_chan_rate[5:3] == {1'b0, $past(i_pwm_rate_code[3:2])})
      else $error("rate code not followed");
endmodule // driver_regs_assertions

bind driver_config_status_regs driver_regs_assertions #(
   .N_CHAN(N_CHAN), .N_LOAD_FLAG(N_LOAD_FLAG)
) chk_u (
   .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_spi_cs_n(i_spi_cs_n),
   .i_supply_uv(i_supply_uv), .i_supply_ov(i_supply_ov), .i_thermal_sd(i_thermal_sd),
   .i_load_fault_flags(i_load_fault_flags), .i_pwm_rate_code(i_pwm_rate_code),
   .o_fast_pwm_select(o_fast_pwm_select), .o_chan_rate(o_chan_rate),
   .o_global_fault_status(o_global_fault_status), .o_outputs_disable(o_outputs_disable)
);
`default_nettype wire

// ### bench/spi_host_model.sv
// host model: drives serial frames, msb first, 30 ns link clock
// assumes the bank samples on rise and shifts out on fall
`default_nettype none
module spi_host_model (
   // link out
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_mosi,
   // link in
   input wire logic  i_miso
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      o_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         o_mosi = tx[15-i];
         #15 o_sclk = 1'b1;
         rx = {rx[14:0], i_miso};
         #15 o_sclk = 1'b0;
      end
      #15 o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      #300;
   endtask
endmodule // spi_host_model
`default_nettype wire

// ### verilog/driver_config_status_regs.sv
// configuration and global status register bank of an eight-fold
// half-bridge driver, reached over a 16-bit serial frame.
// assumes mode 0 serial timing, chip select high at least 4 system clocks
// between frames; fault levels arrive asynchronous, load flags synchronous.
//
// How it works
// - bit 7 of overvoltage/fast control picks 33 V threshold, reset 21 V.
// - bits 6..4 force channels 3..1 to 2 kHz, reset off.
// - reserved bits in all three registers always read zero.
// - bit 6 of second control disables freewheel open-load check, reset 0.
// - bit 4 picks 32 us dead time, reset 0 gives 128 us.
// - bits 2..0 hold the slew-rate code, reset 000.
// - global status holds all zeros after reset.
// - a frame is sixteen bits, address byte first, data byte second.
// - address bit 7 low reads status without change.
// - address bit 7 high with the global status index clears the status clearable flags.
// - status flags other than bit 6 never clear except by host clear command.
// - status bit 7 latches a serial protocol error until cleared.
// - status bit 6 is read-only OR of all load fault flags.
// - undervoltage latches bit 5 and turns all outputs off.
// - overvoltage latches bit 4 and turns all outputs off.
// - bit 3 is 0 after reset, a clear command sets it to 1.
// - thermal shutdown latches bit 2 and turns all outputs off.
// - thermal prewarning latches bit 1, outputs stay on.
// - load error summary follows its flags and falls when all clear.
// - without fast mode the rate code gives off, 80, 100 or 200 Hz.
`default_nettype none

module driver_config_status_regs #(
   parameter int unsigned N_CHAN      = 3,
   parameter int unsigned N_LOAD_FLAG = 32
) (
   // system clock and reset
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_arst_n,
   // serial link
   input  wire logic                     i_spi_sclk,
   input  wire logic                     i_spi_cs_n,
   input  wire logic                     i_spi_mosi,
   output logic                          o_spi_miso,
   output logic                          o_spi_miso_oe,
   // fault detectors, asynchronous levels
   input  wire logic                     i_supply_uv,
   input  wire logic                     i_supply_ov,
   input  wire logic                     i_thermal_sd,
   input  wire logic                     i_thermal_pw,
   // per-channel load flags and rate codes, system domain
   input  wire logic [N_LOAD_FLAG-1:0]   i_load_fault_flags,
   input  wire logic [2*N_CHAN-1:0]      i_pwm_rate_code,
   // configuration outputs
   output logic                          o_ov_thresh_high,
   output logic [N_CHAN-1:0]             o_fast_pwm_select,
   output logic                          o_freewheel_openload_disable,
   output logic                          o_dead_time_short,
   output logic [2:0]                    o_slew_rate_code,
   output logic [3*N_CHAN-1:0]           o_chan_rate,
   // status outputs
   output logic [7:0]                    o_global_fault_status,
   output logic                          o_outputs_disable
);

   // ---------------- link domain ----------------
   logic        frame_rst_n;
   logic        in_frame_r;
   logic        in_frame_nxt;
   logic [4:0]  cnt_r;
   logic [4:0]  cnt_nxt;
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic        tog_r;
   logic        tog_nxt;
   logic        miso_r;
   logic        miso_nxt;
   logic        miso_oe_r;
   logic        miso_oe_nxt;
   logic [7:0]  resp_r;
   logic [7:0]  resp_nxt;

   assign frame_rst_n = i_arst_n & ~i_spi_cs_n;

   // first edge of a frame restarts the count and toggles the frame marker
   always_comb begin
      in_frame_nxt = 1'b1;
      shift_nxt    = {shift_r[14:0], i_spi_mosi};
      tog_nxt      = tog_r;
      cnt_nxt      = cnt_r;
      if (!in_frame_r) begin
         cnt_nxt = 5'h01;
         tog_nxt = ~tog_r;
      end else if (cnt_r != driver_regs_pkg::CNT_MAX) begin
         cnt_nxt = cnt_r + 5'h01;
      end
   end

   always_ff @(posedge i_spi_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         in_frame_r <= 1'b0;
      end else begin
         in_frame_r <= in_frame_nxt;
      end
   end

   always_ff @(posedge i_spi_sclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r   <= 5'h00;
         shift_r <= 16'h0000;
         tog_r   <= 1'b0;
      end else begin
         cnt_r   <= cnt_nxt;
         shift_r <= shift_nxt;
         tog_r   <= tog_nxt;
      end
   end

   // response of the previous frame shifts out during the data byte
   always_comb begin
      miso_oe_nxt = 1'b1;
      miso_nxt    = 1'b0;
      if (cnt_r >= driver_regs_pkg::CNT_DATA_FIRST && cnt_r < driver_regs_pkg::CNT_FRAME) begin
         miso_nxt = resp_r[3'(4'hF - cnt_r[3:0])];
      end
   end

   always_ff @(negedge i_spi_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         miso_r    <= 1'b0;
         miso_oe_r <= 1'b0;
      end else begin
         miso_r    <= miso_nxt;
         miso_oe_r <= miso_oe_nxt;
      end
   end

   assign o_spi_miso    = miso_r;
   assign o_spi_miso_oe = miso_oe_r;

   // ---------------- system domain: synchronisers ----------------
   logic [5:0] sync1_r;
   logic [5:0] sync2_r;
   logic [5:0] sync_nxt;
   logic       cs_n_d_r;
   logic       tog_seen_r;
   logic       cs_n_s;
   logic       tog_s;
   logic       uv_s;
   logic       ov_s;
   logic       tsd_s;
   logic       tpw_s;

   assign sync_nxt = {i_spi_cs_n, tog_r, i_supply_uv, i_supply_ov, i_thermal_sd, i_thermal_pw};
   assign cs_n_s   = sync2_r[5];
   assign tog_s    = sync2_r[4];
   assign uv_s     = sync2_r[3];
   assign ov_s     = sync2_r[2];
   assign tsd_s    = sync2_r[1];
   assign tpw_s    = sync2_r[0];

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1_r <= 6'h20;
         sync2_r <= 6'h20;
      end else begin
         sync1_r <= sync_nxt;
         sync2_r <= sync1_r;
      end
   end

   // ---------------- system domain: command decode ----------------
   logic        frame_end;
   logic        frame_ok;
   logic        cs_n_d_nxt;
   logic        tog_seen_nxt;
   logic [15:0] word_r;
   logic [15:0] word_nxt;
   logic        word_ok_r;
   logic        word_ok_nxt;
   logic        word_vld_r;
   logic        word_vld_nxt;
   logic        op_bit;
   logic [4:0]  idx;
   logic [7:0]  data_byte;
   logic        hit_ov_fast;
   logic        hit_ol_dt_sr;
   logic        hit_global;
   logic        proto_err;

   // chip select has been high for two clocks at frame end, so the link word
   // and bit count are quiet and may be taken across
   assign frame_end = cs_n_s & ~cs_n_d_r;
   assign frame_ok  = (tog_s != tog_seen_r) && (cnt_r == driver_regs_pkg::CNT_FRAME);

   // the frame marker is only taken at frame end; a frame without clock edges
   // leaves it unchanged and so counts as a protocol error
   always_comb begin
      cs_n_d_nxt   = cs_n_s;
      tog_seen_nxt = tog_seen_r;
      word_nxt     = word_r;
      word_ok_nxt  = 1'b0;
      word_vld_nxt = frame_end;
      if (frame_end) begin
         tog_seen_nxt = tog_s;
         word_nxt     = shift_r;
         word_ok_nxt  = frame_ok;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cs_n_d_r   <= 1'b1;
         tog_seen_r <= 1'b0;
         word_r     <= 16'h0000;
         word_ok_r  <= 1'b0;
         word_vld_r <= 1'b0;
      end else begin
         cs_n_d_r   <= cs_n_d_nxt;
         tog_seen_r <= tog_seen_nxt;
         word_r     <= word_nxt;
         word_ok_r  <= word_ok_nxt;
         word_vld_r <= word_vld_nxt;
      end
   end

   // captured frame, acted on one clock behind the frame end
   assign op_bit       = word_r[driver_regs_pkg::ADDR_OP_BIT];
   assign idx          = word_r[driver_regs_pkg::ADDR_IDX_HI:driver_regs_pkg::ADDR_IDX_LO];
   assign data_byte    = word_r[7:0];
   assign proto_err    = word_vld_r & ~word_ok_r;
   assign hit_ov_fast  = word_vld_r & word_ok_r & (idx == driver_regs_pkg::IDX_OV_FAST);
   assign hit_ol_dt_sr = word_vld_r & word_ok_r & (idx == driver_regs_pkg::IDX_OL_DT_SR);
   assign hit_global   = word_vld_r & word_ok_r & (idx == driver_regs_pkg::IDX_GLOBAL);

   // ---------------- system domain: registers ----------------
   logic [7:0] ov_fast_r;
   logic [7:0] ov_fast_nxt;
   logic [7:0] ol_dt_sr_r;
   logic [7:0] ol_dt_sr_nxt;
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic       off_nxt;
   logic       off_r;

   always_comb begin
      ov_fast_nxt  = ov_fast_r;
      ol_dt_sr_nxt = ol_dt_sr_r;
      status_nxt   = status_r;
      // configuration writes keep only writable positions
      if (hit_ov_fast && op_bit) begin
         ov_fast_nxt = data_byte & driver_regs_pkg::WMASK_OV_FAST;
      end
      if (hit_ol_dt_sr && op_bit) begin
         ol_dt_sr_nxt = data_byte & driver_regs_pkg::WMASK_OL_DT_SR;
      end
      // clear command; hardware sets below win over it
      if (hit_global && op_bit) begin
         status_nxt = status_r & ~driver_regs_pkg::ST_CLEAR_MASK;
         status_nxt[driver_regs_pkg::ST_NO_POWER_ON_RESET_FLAG] = 1'b1;
      end
      if (proto_err) begin
         status_nxt[driver_regs_pkg::ST_PROTO_ERR] = 1'b1;
      end
      if (uv_s) begin
         status_nxt[driver_regs_pkg::ST_UV] = 1'b1;
      end
      if (ov_s) begin
         status_nxt[driver_regs_pkg::ST_OV] = 1'b1;
      end
      if (tsd_s) begin
         status_nxt[driver_regs_pkg::ST_TSD] = 1'b1;
      end
      if (tpw_s) begin
         status_nxt[driver_regs_pkg::ST_TPW] = 1'b1;
      end
      status_nxt[driver_regs_pkg::ST_LOAD_ERR] = |i_load_fault_flags;
      status_nxt[0] = 1'b0;
      off_nxt = status_nxt[driver_regs_pkg::ST_UV] | status_nxt[driver_regs_pkg::ST_OV]
              | status_nxt[driver_regs_pkg::ST_TSD];
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ov_fast_r  <= driver_regs_pkg::RST_OV_FAST;
         ol_dt_sr_r <= driver_regs_pkg::RST_OL_DT_SR;
         status_r   <= driver_regs_pkg::RST_GLOBAL;
         off_r      <= 1'b0;
      end else begin
         ov_fast_r  <= ov_fast_nxt;
         ol_dt_sr_r <= ol_dt_sr_nxt;
         status_r   <= status_nxt;
         off_r      <= off_nxt;
      end
   end

   // response byte holds contents before the captured command acted
   always_comb begin
      resp_nxt = resp_r;
      if (word_vld_r) begin
         resp_nxt = 8'h00;
         if (hit_ov_fast) begin
            resp_nxt = ov_fast_r;
         end else if (hit_ol_dt_sr) begin
            resp_nxt = ol_dt_sr_r;
         end else if (hit_global) begin
            resp_nxt = status_r;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         resp_r <= driver_regs_pkg::RST_RESP;
      end else begin
         resp_r <= resp_nxt;
      end
   end

   // ---------------- per-channel rate resolution ----------------
   genvar ch;
   generate
      for (ch = 0; ch < N_CHAN; ch++) begin : g_chan
         driver_regs_pkg::chan_rate_t rate_nxt;
         driver_regs_pkg::chan_rate_t rate_r;
         logic [1:0]                  code;

         assign code = i_pwm_rate_code[2*ch +: 2];

         always_comb begin
            if (ov_fast_r[driver_regs_pkg::FAST_PWM_LSB + ch]) begin
               rate_nxt = driver_regs_pkg::RATE_2KHZ;
            end else if (code == driver_regs_pkg::RATE_IN_OFF) begin
               rate_nxt = driver_regs_pkg::RATE_OFF;
            end else if (code == driver_regs_pkg::RATE_IN_80HZ) begin
               rate_nxt = driver_regs_pkg::RATE_80HZ;
            end else if (code == driver_regs_pkg::RATE_IN_100HZ) begin
               rate_nxt = driver_regs_pkg::RATE_100HZ;
            end else begin
               rate_nxt = driver_regs_pkg::RATE_200HZ;
            end
         end

         always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
            if (!i_arst_n) begin
               rate_r <= driver_regs_pkg::RATE_OFF;
            end else begin
               rate_r <= rate_nxt;
            end
         end

         assign o_chan_rate[3*ch +: 3] = rate_r;
      end
   endgenerate

   // ---------------- outputs ----------------
   assign o_ov_thresh_high             = ov_fast_r[driver_regs_pkg::OV_THRESH_BIT];
   assign o_fast_pwm_select            = ov_fast_r[driver_regs_pkg::FAST_PWM_LSB +: N_CHAN];
   assign o_freewheel_openload_disable = ol_dt_sr_r[driver_regs_pkg::FREEWHEEL_BIT];
   assign o_dead_time_short            = ol_dt_sr_r[driver_regs_pkg::DEAD_TIME_BIT];
   assign o_slew_rate_code             = ol_dt_sr_r[driver_regs_pkg::SLEW_LSB +: 3];
   assign o_global_fault_status        = status_r;
   assign o_outputs_disable            = off_r;

endmodule // driver_config_status_regs

`default_nettype wire

// ### verilog/driver_regs_pkg.sv
// package: offsets, field positions, reset values and frame constants of the
// configuration and global status register bank.
// assumes a 16-bit serial frame of address byte then data byte.
`default_nettype none

package driver_regs_pkg;

   // frame framing
   localparam logic [4:0] CNT_FRAME       = 5'h10;
   localparam logic [4:0] CNT_MAX         = 5'h11;
   localparam logic [4:0] CNT_DATA_FIRST  = 5'h08;
   localparam int unsigned ADDR_OP_BIT    = 15;
   localparam int unsigned ADDR_IDX_HI    = 14;
   localparam int unsigned ADDR_IDX_LO    = 10;

   // register index, address byte bits 6..2
   localparam logic [4:0] IDX_OV_FAST     = 5'h03;
   localparam logic [4:0] IDX_OL_DT_SR    = 5'h07;
   localparam logic [4:0] IDX_GLOBAL      = 5'h06;

   // reset values and writable masks
   localparam logic [7:0] RST_OV_FAST     = 8'h00;
   localparam logic [7:0] RST_OL_DT_SR    = 8'h00;
   localparam logic [7:0] RST_GLOBAL      = 8'h00;
   localparam logic [7:0] RST_RESP        = 8'h00;
   localparam logic [7:0] WMASK_OV_FAST   = 8'hF0;
   localparam logic [7:0] WMASK_OL_DT_SR  = 8'h57;

   // configuration fields
   localparam int unsigned OV_THRESH_BIT  = 7;
   localparam int unsigned FAST_PWM_LSB   = 4;
   localparam int unsigned FREEWHEEL_BIT  = 6;
   localparam int unsigned DEAD_TIME_BIT  = 4;
   localparam int unsigned SLEW_LSB       = 0;

   // global status fields
   localparam int unsigned ST_PROTO_ERR   = 7;
   localparam int unsigned ST_LOAD_ERR    = 6;
   localparam int unsigned ST_UV          = 5;
   localparam int unsigned ST_OV          = 4;
   localparam int unsigned ST_NO_POWER_ON_RESET_FLAG        = 3;
   localparam int unsigned ST_TSD         = 2;
   localparam int unsigned ST_TPW         = 1;
   localparam logic [7:0] ST_CLEAR_MASK   = 8'hB6;

   // per-channel rate code from the external rate register
   localparam logic [1:0] RATE_IN_OFF     = 2'h0;
   localparam logic [1:0] RATE_IN_80HZ    = 2'h1;
   localparam logic [1:0] RATE_IN_100HZ   = 2'h2;

   // resolved channel rate
   typedef enum logic [2:0] {
      RATE_OFF,
      RATE_80HZ,
      RATE_100HZ,
      RATE_200HZ,
      RATE_2KHZ
   } chan_rate_t;

endpackage

`default_nettype wire
